// ---- hdl/pfc_pkg.sv ----
// package: command codes, field layout, reset values and timing for the feature config words
package pfc_pkg;
  localparam logic [7:0]  CMD_MFR_CFG      = 8'hd0;
  localparam logic [7:0]  CMD_USER_CFG     = 8'hd1;
  localparam logic [15:0] MFR_CFG_RST      = 16'h6a11;
  localparam logic [15:0] USER_CFG_RST     = 16'h2011;
  // manufacturer word fields
  localparam int MFR_BLANK_LSB  = 11;
  localparam int MFR_FCNT_LSB   = 8;
  localparam int MFR_XT_EN_BIT  = 7;
  localparam int MFR_XT_SEL_BIT = 6;
  localparam int MFR_SENSE_LSB  = 4;
  localparam int MFR_NONLIN_BIT = 3;
  localparam int MFR_ALTR_BIT   = 2;
  localparam int MFR_PGPP_BIT   = 1;
  localparam int MFR_SYPP_BIT   = 0;
  // user word fields
  localparam int USR_MIND_LSB   = 14;
  localparam int USR_MIND_EN    = 13;
  localparam int USR_SYTO_BIT   = 11;
  localparam int USR_FF_DIS_BIT = 9;
  localparam int USR_SPREAD_BIT = 8;
  localparam int USR_SYSRC_BIT  = 6;
  localparam int USR_SYOUT_BIT  = 5;
  localparam int USR_LSOFF_BIT  = 2;
  localparam int USR_STBY_LSB   = 0;
  // timing
  localparam int BLANK_STEP_NS  = 32;
  localparam int CLK_NS         = 20;
  localparam int SYNC_TO_MS     = 500;
  localparam int CLK_HZ         = 50000000;
  localparam int SYNC_TO_CYC    = CLK_HZ / 1000 * SYNC_TO_MS;
  localparam int ID_W           = 5;

  typedef enum logic [1:0] {PFC_SNS_GND_DN, PFC_SNS_OUT_DN, PFC_SNS_OUT_UP,
                            PFC_SNS_RSVD} pfc_sense_t;
  typedef enum logic [1:0] {PFC_STBY_LOWPWR, PFC_STBY_MONITOR, PFC_STBY_RSVD,
                            PFC_STBY_PULSED} pfc_stby_t;

  // word command toward the register bank
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  cmd;
    logic [15:0] data;
  } pfc_req_t;

  // decoded controls handed to the power stage
  typedef struct packed {
    logic [4:0]  blank_steps;
    logic [3:0]  fault_limit;
    logic        xt_meas_en;
    logic        xt_sel;
    pfc_sense_t  sense_mode;
    logic        nonlinear_response;
    logic        alt_ramp;
    logic        power_good_push_pull;
    logic        sync_push_pull;
    logic        min_duty_en;
    logic [7:0]  min_duty;
    logic        ff_enable;
    logic        ext_sync;
    pfc_stby_t   stby_mode;
  } pfc_ctl_t;
endpackage

// ---- hdl/pfc_fault_filter.sv ----
// consecutive-violation filter for current faults
`timescale 1ns/1ns
module pfc_fault_filter #(
  parameter int CNT_W = 4
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             sample,
  input  wire logic             violation,
  input  wire logic [CNT_W-1:0] limit,
  input  wire logic             clear,
  output logic                  fault
);
  logic [CNT_W-1:0] run_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_r <= '0;
    end else if (clear) begin
      run_r <= '0;
    end else if (sample) begin
      if (!violation) begin
        run_r <= '0;
      end else if (run_r < limit) begin
        run_r <= run_r + 1'b1;
      end
    end
  end

  // fault after limit consecutive violating samples
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault <= 1'b0;
    end else if (sample && violation && (run_r + 1'b1 >= limit)) begin
      fault <= 1'b1;
    end else if (clear) begin
      fault <= 1'b0;
    end
  end
endmodule

// ---- hdl/pfc_sync_timer.sv ----
// disable-time counter that stops the sync pin output
`timescale 1ns/1ns
module pfc_sync_timer #(
  parameter int TO_CYC = 25000000
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic enabled,
  input  wire logic timeout_en,
  output logic      expired
);
  localparam int W = $clog2(TO_CYC + 1);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (enabled) begin
      cnt_r <= '0;
    end else if (cnt_r != W'(TO_CYC)) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      expired <= 1'b0;
    end else begin
      expired <= timeout_en && !enabled && (cnt_r == W'(TO_CYC));
    end
  end
endmodule

// ---- hdl/pfc_feature_config.sv ----
// feature configuration words and the controls they steer
`timescale 1ns/1ns
module pfc_feature_config #(
  parameter int SYNC_TO_CYC = pfc_pkg::SYNC_TO_CYC
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // word command port from the management interface
  input  wire pfc_pkg::pfc_req_t req,
  output logic                   rd_valid,
  output logic [15:0]            rd_data,
  output logic                   cmd_hit,
  // device state
  input  wire logic              enabled,
  input  wire logic              ramping,
  input  wire logic              power_good,
  input  wire logic              sequencing_en,
  input  wire logic              internal_osc,
  input  wire logic              int_sw_clk,
  input  wire logic              sync_in,
  input  wire logic              sense_sample,
  input  wire logic              overcurrent,
  input  wire logic              undercurrent,
  input  wire logic [7:0]        duty_req,
  input  wire logic              remote_fault,
  input  wire logic [4:0]        remote_rail_id,
  input  wire logic [31:0]       fault_group_select,
  input  wire logic [4:0]        rail_id,
  input  wire logic              temp_convert,
  // controls out
  output pfc_pkg::pfc_ctl_t      ctl,
  output logic [7:0]             blank_ns,
  output logic                   overcurrent_fault,
  output logic                   undercurrent_fault,
  output logic                   xt_convert,
  output logic                   temp_use_ext,
  output logic [7:0]             duty_out,
  output logic                   sw_clk,
  output logic                   sync_out,
  output logic                   sync_oe,
  output logic                   low_side_on,
  output logic                   shutdown_now,
  output logic                   seq_down_req,
  output logic [4:0]             seq_down_from,
  output logic                   telemetry_on,
  output logic                   monitor_pulse
);
  logic [15:0] mfr_r;
  logic [15:0] usr_r;
  logic        over_flt;
  logic        under_flt;
  logic        sync_exp;
  logic [3:0]  flimit;
  logic [7:0]  duty_floor;
  logic        pulse_r;

  // register writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mfr_r <= pfc_pkg::MFR_CFG_RST;
    end else if (req.wr && req.cmd == pfc_pkg::CMD_MFR_CFG) begin
      mfr_r <= req.data;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      usr_r <= pfc_pkg::USER_CFG_RST;
    end else if (req.wr && req.cmd == pfc_pkg::CMD_USER_CFG) begin
      usr_r <= req.data;
    end
  end

  // read answer, one cycle after request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_valid <= 1'b0;
      rd_data  <= 16'h0000;
      cmd_hit  <= 1'b0;
    end else begin
      rd_valid <= req.rd;
      cmd_hit  <= (req.rd || req.wr) &&
                  (req.cmd == pfc_pkg::CMD_MFR_CFG || req.cmd == pfc_pkg::CMD_USER_CFG);
      if (req.rd) begin
        case (req.cmd)
          pfc_pkg::CMD_MFR_CFG:  rd_data <= mfr_r;
          pfc_pkg::CMD_USER_CFG: rd_data <= usr_r;
          default:               rd_data <= 16'h0000;
        endcase
      end
    end
  end

  // decoded control word
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl <= '0;
    end else begin
      ctl.blank_steps    <= mfr_r[pfc_pkg::MFR_BLANK_LSB +: 5];
      ctl.fault_limit    <= flimit;
      ctl.xt_meas_en     <= mfr_r[pfc_pkg::MFR_XT_EN_BIT];
      ctl.xt_sel         <= mfr_r[pfc_pkg::MFR_XT_SEL_BIT];
      ctl.sense_mode     <= pfc_pkg::pfc_sense_t'(mfr_r[pfc_pkg::MFR_SENSE_LSB +: 2]);
      ctl.nonlinear_response   <= mfr_r[pfc_pkg::MFR_NONLIN_BIT];
      ctl.alt_ramp             <= mfr_r[pfc_pkg::MFR_ALTR_BIT];
      ctl.power_good_push_pull <= mfr_r[pfc_pkg::MFR_PGPP_BIT];
      ctl.sync_push_pull <= mfr_r[pfc_pkg::MFR_SYPP_BIT];
      ctl.min_duty_en    <= usr_r[pfc_pkg::USR_MIND_EN];
      ctl.min_duty       <= duty_floor;
      ctl.ff_enable      <= !usr_r[pfc_pkg::USR_FF_DIS_BIT];
      ctl.ext_sync       <= usr_r[pfc_pkg::USR_SYSRC_BIT];
      ctl.stby_mode      <= pfc_pkg::pfc_stby_t'(usr_r[pfc_pkg::USR_STBY_LSB +: 2]);
    end
  end

  // blanking delay counted in 32 ns steps
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blank_ns <= 8'h00;
    end else begin
      blank_ns <= {3'h0, mfr_r[pfc_pkg::MFR_BLANK_LSB +: 5]};
    end
  end

  assign flimit = {mfr_r[pfc_pkg::MFR_FCNT_LSB +: 3], 1'b1};

  // floor taken from the live word so enable and value move together
  assign duty_floor = {6'h00, usr_r[pfc_pkg::USR_MIND_LSB +: 2]} + 8'h01;

  pfc_fault_filter #(.CNT_W(4)) u_over (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .sample    (sense_sample),
    .violation (overcurrent),
    .limit     (flimit),
    .clear     (!enabled),
    .fault     (over_flt)
  );

  pfc_fault_filter #(.CNT_W(4)) u_under (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .sample    (sense_sample),
    .violation (undercurrent),
    .limit     (flimit),
    .clear     (!enabled),
    .fault     (under_flt)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      overcurrent_fault  <= 1'b0;
      undercurrent_fault <= 1'b0;
    end else begin
      overcurrent_fault  <= over_flt;
      undercurrent_fault <= under_flt;
    end
  end

  // temperature source and external conversions
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xt_convert   <= 1'b0;
      temp_use_ext <= 1'b0;
    end else begin
      xt_convert   <= temp_convert && mfr_r[pfc_pkg::MFR_XT_EN_BIT];
      temp_use_ext <= mfr_r[pfc_pkg::MFR_XT_SEL_BIT];
    end
  end

  // minimum duty during ramp
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      duty_out <= 8'h00;
    end else if (ramping && usr_r[pfc_pkg::USR_MIND_EN] && duty_req < duty_floor) begin
      duty_out <= duty_floor;
    end else begin
      duty_out <= duty_req;
    end
  end

  pfc_sync_timer #(.TO_CYC(SYNC_TO_CYC)) u_sto (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .enabled    (enabled),
    .timeout_en (usr_r[pfc_pkg::USR_SYTO_BIT]),
    .expired    (sync_exp)
  );

  // switch clock source and sync pin drive
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_clk   <= 1'b0;
      sync_out <= 1'b0;
      sync_oe  <= 1'b0;
    end else begin
      if (usr_r[pfc_pkg::USR_SYSRC_BIT] || !internal_osc) begin
        sw_clk <= sync_in;
      end else begin
        sw_clk <= int_sw_clk;
      end
      if (usr_r[pfc_pkg::USR_SYOUT_BIT] && internal_osc &&
          !usr_r[pfc_pkg::USR_SYSRC_BIT] && !sync_exp) begin
        sync_out <= int_sw_clk;
        // open drain only pulls low
        sync_oe  <= mfr_r[pfc_pkg::MFR_SYPP_BIT] || !int_sw_clk;
      end else begin
        sync_out <= 1'b0;
        sync_oe  <= 1'b0;
      end
    end
  end

  // low-side drive while disabled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_side_on <= 1'b0;
    end else begin
      low_side_on <= !enabled && usr_r[pfc_pkg::USR_LSOFF_BIT];
    end
  end

  // fault spreading among rails
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shutdown_now  <= 1'b0;
      seq_down_req  <= 1'b0;
      seq_down_from <= 5'h00;
    end else begin
      shutdown_now <= remote_fault && usr_r[pfc_pkg::USR_SPREAD_BIT] &&
                      fault_group_select[remote_rail_id] && remote_rail_id != rail_id;
      seq_down_req <= remote_fault && !usr_r[pfc_pkg::USR_SPREAD_BIT] &&
                      sequencing_en && remote_rail_id != rail_id;
      if (remote_fault) begin
        seq_down_from <= remote_rail_id;
      end
    end
  end

  // standby behaviour
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      telemetry_on  <= 1'b1;
      monitor_pulse <= 1'b0;
      pulse_r       <= 1'b0;
    end else begin
      pulse_r <= req.rd;
      if (enabled) begin
        telemetry_on  <= 1'b1;
        monitor_pulse <= 1'b0;
      end else begin
        case (pfc_pkg::pfc_stby_t'(usr_r[pfc_pkg::USR_STBY_LSB +: 2]))
          pfc_pkg::PFC_STBY_MONITOR: begin
            telemetry_on  <= 1'b1;
            monitor_pulse <= 1'b0;
          end
          pfc_pkg::PFC_STBY_PULSED: begin
            telemetry_on  <= 1'b0;
            monitor_pulse <= pulse_r;
          end
          default: begin
            telemetry_on  <= 1'b0;
            monitor_pulse <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// ---- tb/pfc_feature_config_sva.sv ----
// port-level assertions for the feature config block
`timescale 1ns/1ns
module pfc_feature_config_sva (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire pfc_pkg::pfc_req_t req,
  input wire logic              rd_valid,
  input wire logic              cmd_hit,
  input wire logic              enabled,
  input wire logic              ramping,
  input wire logic              temp_convert,
  input wire logic              internal_osc,
  input wire logic              remote_fault,
  input wire logic [4:0]        remote_rail_id,
  input wire logic [31:0]       fault_group_select,
  input wire logic [4:0]        rail_id,
  input wire logic              sequencing_en,
  input wire pfc_pkg::pfc_ctl_t ctl,
  input wire logic [7:0]        blank_ns,
  input wire logic              overcurrent_fault,
  input wire logic              undercurrent_fault,
  input wire logic              xt_convert,
  input wire logic              temp_use_ext,
  input wire logic [7:0]        duty_out,
  input wire logic              sync_oe,
  input wire logic              low_side_on,
  input wire logic              shutdown_now,
  input wire logic              seq_down_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // cmd d0 and d1 share bits 7:1
  a_word_answer: assert property ((req.rd || req.wr) && req.cmd[7:1] == 7'h68 |=>
    cmd_hit && rd_valid == $past(req.rd)) else $error("word command not answered");
  a_other_cmd: assert property (req.cmd[7:1] != 7'h68 |=> !cmd_hit)
    else $error("hit on unmapped command");
  a_blank_steps: assert property (blank_ns == {3'h0, ctl.blank_steps})
    else $error("blanking delay mismatch");
  a_odd_limit: assert property (!$past(sys_rst) |-> ctl.fault_limit[0])
    else $error("fault limit not odd");
  a_fault_clear: assert property (!enabled [*3] |->
    !overcurrent_fault && !undercurrent_fault) else $error("current fault held while disabled");
  a_xt_gate: assert property (xt_convert |-> $past(temp_convert) && ctl.xt_meas_en)
    else $error("external conversion while off");
  a_temp_src: assert property (temp_use_ext == ctl.xt_sel)
    else $error("temperature source mismatch");
  a_duty_floor: assert property ($past(ramping) && ctl.min_duty_en |->
    duty_out >= ctl.min_duty) else $error("ramp duty below floor");
  a_group_stop: assert property (shutdown_now |-> $past(remote_fault &&
    fault_group_select[remote_rail_id] && remote_rail_id != rail_id))
    else $error("shutdown without group fault");
  a_seq_down: assert property (seq_down_req |-> $past(remote_fault && sequencing_en)
    && !shutdown_now) else $error("sequence down without cause");
  a_sync_drive: assert property (sync_oe |-> $past(internal_osc))
    else $error("sync driven without internal oscillator");
  a_low_side: assert property (low_side_on |-> $past(!enabled))
    else $error("low side on while enabled");
endmodule
bind pfc_feature_config pfc_feature_config_sva i_sva (.clk, .sys_rst, .req, .rd_valid,
  .cmd_hit, .enabled, .ramping, .temp_convert, .internal_osc, .remote_fault, .remote_rail_id,
  .fault_group_select, .rail_id, .sequencing_en, .ctl, .blank_ns, .overcurrent_fault,
  .undercurrent_fault, .xt_convert, .temp_use_ext, .duty_out, .sync_oe, .low_side_on,
  .shutdown_now, .seq_down_req);

// ---- tb/pfc_host_model.sv ----
// management host issuing word commands
`timescale 1ns/1ns
module pfc_host_model (
  input  wire logic         clk,
  output pfc_pkg::pfc_req_t req,
  input  wire logic         rd_valid,
  input  wire logic [15:0]  rd_data,
  input  wire logic         cmd_hit
);
  initial req = '0;
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    if (c == pfc_pkg::CMD_MFR_CFG && d[6]) d[7] = 1'b1;
    @(posedge clk) req <= '{1'b1, 1'b0, c, d};
    @(posedge clk) req <= '0;
  endtask
  // answer is {rd_valid, cmd_hit, rd_data}
  task automatic rd(input logic [7:0] c, output logic [17:0] a);
    @(posedge clk) req <= '{1'b0, 1'b1, c, 16'h0};
    @(posedge clk) req <= '0;
    @(posedge clk) a = {rd_valid, cmd_hit, rd_data};
  endtask
endmodule

// ---- tb/pfc_feature_config_tb.sv ----
// testbench for the feature config block
`timescale 1ns/1ns
module pfc_feature_config_tb;
  logic clk, sys_rst, enabled, ramping, power_good, sequencing_en, internal_osc, int_sw_clk;
  logic sync_in, sense_sample, overcurrent, undercurrent, temp_convert, remote_fault;
  logic rd_valid, cmd_hit, overcurrent_fault, undercurrent_fault, xt_convert, temp_use_ext;
  logic sw_clk, sync_out, sync_oe, low_side_on, shutdown_now, seq_down_req, telemetry_on;
  logic monitor_pulse;
  logic [7:0]        duty_req, blank_ns, duty_out;
  logic [4:0]        remote_rail_id, rail_id, seq_down_from;
  logic [31:0]       fault_group_select;
  logic [15:0]       rd_data;
  logic [17:0]       r;
  pfc_pkg::pfc_req_t req;
  pfc_pkg::pfc_ctl_t ctl;
  int                err_count, tests_run;

  pfc_feature_config #(.SYNC_TO_CYC(50)) i_dut (.clk, .sys_rst, .req, .rd_valid, .rd_data,
    .cmd_hit, .enabled, .ramping, .power_good, .sequencing_en, .internal_osc, .int_sw_clk,
    .sync_in, .sense_sample, .overcurrent, .undercurrent, .duty_req, .remote_fault,
    .remote_rail_id, .fault_group_select, .rail_id, .temp_convert, .ctl, .blank_ns,
    .overcurrent_fault, .undercurrent_fault, .xt_convert, .temp_use_ext, .duty_out, .sw_clk,
    .sync_out, .sync_oe,
    .low_side_on, .shutdown_now, .seq_down_req, .seq_down_from, .telemetry_on, .monitor_pulse);
  pfc_host_model i_host (.clk, .req, .rd_valid, .rd_data, .cmd_hit);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wm(input logic [15:0] d);
    i_host.wr(pfc_pkg::CMD_MFR_CFG, d);
    tk(2);
  endtask
  task automatic wu(input logic [15:0] d);
    i_host.wr(pfc_pkg::CMD_USER_CFG, d);
    tk(2);
  endtask

  task automatic t_regs;
    i_host.rd(pfc_pkg::CMD_MFR_CFG, r);
    chk("mfr reset", r, 18'h36a11);
    i_host.rd(pfc_pkg::CMD_USER_CFG, r);
    chk("usr reset", r, 18'h32011);
    i_host.wr(8'hd2, 16'h5555);
    i_host.rd(8'hd2, r);
    chk("unmapped", r, 18'h20000);
    i_host.wr(pfc_pkg::CMD_USER_CFG, 16'hffff);
    i_host.rd(pfc_pkg::CMD_USER_CFG, r);
    chk("usr all ones", r, 18'h3ffff);
    i_host.wr(pfc_pkg::CMD_MFR_CFG, 16'h1234);
    i_host.rd(pfc_pkg::CMD_MFR_CFG, r);
    chk("mfr write", r, 18'h31234);
  endtask

  task automatic t_fields;
    @(posedge clk) temp_convert <= 1'b1;
    wm(16'hfbe1);
    chk("blank", blank_ns, 8'h1f);
    chk("limit", ctl.fault_limit, 4'h7);
    chk("xt conv", xt_convert, 1'b1);
    chk("ext src", temp_use_ext, 1'b1);
    wm(16'h6a11);
    chk("xt off", xt_convert, 1'b0);
    chk("int src", temp_use_ext, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wm(16'h0101 | 16'(i << 4));
      chk("sense", ctl.sense_mode, i);
    end
  endtask

  // limit is 3 with the field at 1
  task automatic t_fault;
    @(posedge clk) begin
      enabled <= 1'b1;
      overcurrent <= 1'b1;
      undercurrent <= 1'b1;
      sense_sample <= 1'b1;
    end
    @(posedge clk);
    @(posedge clk) sense_sample <= 1'b0;
    tk(4);
    chk("over early", overcurrent_fault, 1'b0);
    chk("under early", undercurrent_fault, 1'b0);
    @(posedge clk) sense_sample <= 1'b1;
    @(posedge clk) sense_sample <= 1'b0;
    tk(4);
    chk("over third", overcurrent_fault, 1'b1);
    chk("under third", undercurrent_fault, 1'b1);
    @(posedge clk) enabled <= 1'b0;
    tk(3);
    chk("over clear", overcurrent_fault, 1'b0);
    chk("under clear", undercurrent_fault, 1'b0);
  endtask

  task automatic t_duty;
    @(posedge clk) ramping <= 1'b1;
    wu(16'he000);
    chk("duty floor", duty_out, 8'h04);
    chk("ff on", ctl.ff_enable, 1'b1);
    wu(16'h0200);
    chk("duty free", duty_out, 8'h02);
    chk("ff off", ctl.ff_enable, 1'b0);
    @(posedge clk) ramping <= 1'b0;
  endtask

  task automatic t_sync;
    wu(16'h0820);
    @(posedge clk) begin
      enabled <= 1'b1;
      internal_osc <= 1'b1;
    end
    tk(3);
    chk("sync drive", sync_oe, 1'b1);
    chk("sw int", sw_clk, 1'b1);
    chk("sync level", sync_out, 1'b1);
    wm(16'h0130);
    chk("open drain high", sync_oe, 1'b0);
    @(posedge clk) int_sw_clk <= 1'b0;
    tk(2);
    chk("open drain low", sync_oe, 1'b1);
    chk("sync low", sync_out, 1'b0);
    @(posedge clk) int_sw_clk <= 1'b1;
    wm(16'h0131);
    @(posedge clk) enabled <= 1'b0;
    tk(30);
    chk("sync hold", sync_oe, 1'b1);
    tk(30);
    chk("sync stop", sync_oe, 1'b0);
    wu(16'h0020);
    chk("sync free run", sync_oe, 1'b1);
    wu(16'h0860);
    chk("sw ext", sw_clk, 1'b0);
    chk("sync in only", sync_oe, 1'b0);
  endtask

  task automatic t_spread;
    wu(16'h0100);
    @(posedge clk) begin
      remote_fault <= 1'b1;
      sequencing_en <= 1'b1;
    end
    tk(2);
    chk("group stop", shutdown_now, 1'b1);
    chk("no seq", seq_down_req, 1'b0);
    @(posedge clk) fault_group_select <= 32'h0000_0002;
    tk(2);
    chk("outside group", shutdown_now, 1'b0);
    @(posedge clk) remote_rail_id <= 5'h01;
    tk(2);
    chk("own rail", shutdown_now, 1'b0);
    @(posedge clk) begin
      remote_rail_id <= 5'h03;
      fault_group_select <= 32'h0000_0008;
    end
    wu(16'h0000);
    chk("no stop", shutdown_now, 1'b0);
    chk("seq down", seq_down_req, 1'b1);
    chk("seq from", seq_down_from, 5'h03);
    @(posedge clk) sequencing_en <= 1'b0;
    tk(2);
    chk("ignored", seq_down_req, 1'b0);
    @(posedge clk) remote_fault <= 1'b0;
  endtask

  task automatic t_stby;
    for (int i = 0; i < 4; i++) begin
      wu(16'h0004 | 16'(i));
      chk("stby mode", ctl.stby_mode, i);
      chk("telemetry", telemetry_on, i == 1);
      chk("ls on", low_side_on, 1'b1);
    end
    chk("pulse idle", monitor_pulse, 1'b0);
    i_host.rd(pfc_pkg::CMD_USER_CFG, r);
    #1;
    chk("pulsed read", monitor_pulse, 1'b1);
    chk("usr stby", r, 18'h30007);
    tk(1);
    chk("pulse ends", monitor_pulse, 1'b0);
    wu(16'h0000);
    chk("ls off", low_side_on, 1'b0);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    {sys_rst, enabled, ramping, power_good, sequencing_en, internal_osc} = 6'h21;
    {sync_in, sense_sample, overcurrent, undercurrent, temp_convert, remote_fault} = 6'h0;
    int_sw_clk = 1'b1;
    duty_req = 8'h02;
    remote_rail_id = 5'h03;
    rail_id = 5'h01;
    fault_group_select = 32'h8;
    err_count = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_fields();
    t_fault();
    t_duty();
    t_sync();
    t_spread();
    t_stby();
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule
